// >>> hdl/dswb_regs.svh
// register offsets, field positions and constants of the drive status bank
`ifndef DSWB_REGS_SVH
`define DSWB_REGS_SVH

`define DSWB_ADDR_STATUS   12'h000
`define DSWB_ADDR_SPEED    12'h004
`define DSWB_ADDR_STATUS2  12'h008
`define DSWB_ADDR_RATED    12'h00c

`define DSWB_RATED_RESET   16'h0258
`define DSWB_SCALE_SHIFT   13'h0000
`define DSWB_SPEED_ZERO    16'h0000
`define DSWB_SPEED_RATED   16'h2000
`define DSWB_SPEED_MAX     16'h7fff
`define DSWB_SPEED_MIN     16'h8000
`define DSWB_Q_MAX         29'h00007fff
`define DSWB_Q_MIN_MAG     29'h00008000
`define DSWB_DIV_STEPS     5'h1d
`define DSWB_WORD_ZERO     16'h0000

`define DSWB_P_RUN_CMD     1
`define DSWB_P_FIRE        2
`define DSWB_P_RAMP2       5
`define DSWB_P_CONFIG      6
`define DSWB_P_ALARM       7
`define DSWB_P_RUNNING     8
`define DSWB_P_ENABLED     9
`define DSWB_P_FORWARD     10
`define DSWB_P_INCHING     11
`define DSWB_P_REMOTE      12
`define DSWB_P_UNDERVOLT   13
`define DSWB_P_FAULT       15

`define DSWB_S_DC_EXT      2
`define DSWB_S_ENERGY      3
`define DSWB_S_FREQ_RED    4
`define DSWB_S_DECEL       6
`define DSWB_S_ACCEL       7
`define DSWB_S_FROZEN      8
`define DSWB_S_SETPOINT    9
`define DSWB_S_DC_REG      10
`define DSWB_S_CFG_50HZ    11
`define DSWB_S_RIDE        12
`define DSWB_S_FLYING      13
`define DSWB_S_DC_BRAKE    14
`define DSWB_S_PULSES      15

`endif

// >>> hdl/dswb_pkg.sv
// types shared by the drive status bank modules
package dswb_pkg;

  typedef struct packed {
    logic run_cmd;
    logic fire_mode;
    logic second_ramp;
    logic config_state;
    logic alarm;
    logic running;
    logic enabled;
    logic forward;
    logic inching_function;
    logic remote;
    logic undervoltage;
    logic fault;
    logic dc_link_extended;
    logic energy_saving;
    logic freq_reduction;
    logic decel_ramp;
    logic accel_ramp;
    logic ramp_frozen;
    logic setpoint_ok;
    logic dc_link_reg;
    logic cfg_50hz;
    logic ride_through;
    logic flying_start;
    logic dc_braking;
    logic pulses_on;
  } dswb_flags_t;

  typedef enum logic [0:0] {
    DSWB_SP_IDLE = 1'b0,
    DSWB_SP_WAIT = 1'b1
  } dswb_sp_state_t;

endpackage : dswb_pkg

// >>> hdl/dswb_if.sv
// carriers between the bank top, the word packer and the divider
`timescale 1ns/1ps
interface dswb_word_if;
  import dswb_pkg::*;
  dswb_flags_t flags;
  logic [15:0] primary;
  logic [15:0] secondary;
  modport packer (input flags, output primary, secondary);
  modport user   (output flags, input primary, secondary);
endinterface : dswb_word_if

interface dswb_div_if;
  logic        start;
  logic [28:0] dividend;
  logic [15:0] divisor;
  logic        busy;
  logic        done;
  logic [28:0] quotient;
  modport divider (input start, dividend, divisor, output busy, done, quotient);
  modport user    (output start, dividend, divisor, input busy, done, quotient);
endinterface : dswb_div_if

// >>> hdl/dswb_word_pack.sv
// registers the drive flags into the two status words
`timescale 1ns/1ps
`include "dswb_regs.svh"
module dswb_word_pack (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flags in, words out
  dswb_word_if.packer words
);
  typedef struct packed {
    logic [15:0] primary;
    logic [15:0] secondary;
  } dswb_pack_state_t;

  dswb_pack_state_t s_reg;
  dswb_pack_state_t s_next;

  always_comb begin
    s_next = '0;
    s_next.primary[`DSWB_P_RUN_CMD]   = words.flags.run_cmd;
    s_next.primary[`DSWB_P_FIRE]      = words.flags.fire_mode;
    s_next.primary[`DSWB_P_RAMP2]     = words.flags.second_ramp;
    s_next.primary[`DSWB_P_CONFIG]    = words.flags.config_state;
    s_next.primary[`DSWB_P_ALARM]     = words.flags.alarm;
    s_next.primary[`DSWB_P_RUNNING]   = words.flags.running;
    s_next.primary[`DSWB_P_ENABLED]   = words.flags.enabled;
    s_next.primary[`DSWB_P_FORWARD]   = words.flags.forward;
    s_next.primary[`DSWB_P_INCHING]   = words.flags.inching_function;
    s_next.primary[`DSWB_P_REMOTE]    = words.flags.remote;
    s_next.primary[`DSWB_P_UNDERVOLT] = words.flags.undervoltage;
    s_next.primary[`DSWB_P_FAULT]     = words.flags.fault;
    s_next.secondary[`DSWB_S_DC_EXT]   = words.flags.dc_link_extended;
    s_next.secondary[`DSWB_S_ENERGY]   = words.flags.energy_saving;
    s_next.secondary[`DSWB_S_FREQ_RED] = words.flags.freq_reduction;
    s_next.secondary[`DSWB_S_DECEL]    = words.flags.decel_ramp;
    s_next.secondary[`DSWB_S_ACCEL]    = words.flags.accel_ramp;
    s_next.secondary[`DSWB_S_FROZEN]   = words.flags.ramp_frozen;
    s_next.secondary[`DSWB_S_SETPOINT] = words.flags.setpoint_ok;
    s_next.secondary[`DSWB_S_DC_REG]   = words.flags.dc_link_reg;
    s_next.secondary[`DSWB_S_CFG_50HZ] = words.flags.cfg_50hz;
    s_next.secondary[`DSWB_S_RIDE]     = words.flags.ride_through;
    s_next.secondary[`DSWB_S_FLYING]   = words.flags.flying_start;
    s_next.secondary[`DSWB_S_DC_BRAKE] = words.flags.dc_braking;
    s_next.secondary[`DSWB_S_PULSES]   = words.flags.pulses_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign words.primary   = s_reg.primary;
  assign words.secondary = s_reg.secondary;

  // unused positions are never written, so they stay low
  a_reserved_low : assert property (@(posedge pclk) disable iff (!presetn)
    (words.primary[0] | words.primary[3] | words.primary[4] | words.primary[14]
     | words.secondary[0] | words.secondary[1] | words.secondary[5]) == 1'b0)
    else $error("reserved status bit set");
endmodule : dswb_word_pack

// >>> hdl/dswb_speed_div.sv
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`include "dswb_regs.svh"
module dswb_speed_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request and answer
  dswb_div_if.divider div
);
  typedef struct packed {
    logic [15:0] rem;
    logic [28:0] quo;
    logic [4:0]  cnt;
    logic        busy;
    logic        done;
  } dswb_div_state_t;

  dswb_div_state_t s_reg;
  dswb_div_state_t s_next;
  logic [16:0]     trial;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    trial       = {s_reg.rem, s_reg.quo[28]};
    if (!s_reg.busy) begin
      if (div.start) begin
        s_next.rem  = '0;
        s_next.quo  = div.dividend;
        s_next.cnt  = `DSWB_DIV_STEPS;
        s_next.busy = 1'b1;
      end
    end else begin
      // a zero divisor yields all ones, which the caller saturates
      if (trial >= {1'b0, div.divisor}) begin
        s_next.rem = 16'(trial - {1'b0, div.divisor});
        s_next.quo = {s_reg.quo[27:0], 1'b1};
      end else begin
        s_next.rem = trial[15:0];
        s_next.quo = {s_reg.quo[27:0], 1'b0};
      end
      s_next.cnt = 5'(s_reg.cnt - 5'h01);
      if (s_reg.cnt == 5'h01) begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign div.busy     = s_reg.busy;
  assign div.done     = s_reg.done;
  assign div.quotient = s_reg.quo;
endmodule : dswb_speed_div

// >>> hdl/dswb_top.sv
// drive status word bank: three read-only words and a rated frequency setting over apb
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "dswb_regs.svh"
module dswb_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // primary status sources
  input  wire logic        run_cmd,
  input  wire logic        fire_mode,
  input  wire logic        second_ramp,
  input  wire logic        config_state,
  input  wire logic        alarm,
  input  wire logic        running,
  input  wire logic        enabled,
  input  wire logic        forward,
  input  wire logic        inching_function,
  input  wire logic        remote,
  input  wire logic        undervoltage,
  input  wire logic        fault,
  // secondary status sources
  input  wire logic        dc_link_extended,
  input  wire logic        energy_saving,
  input  wire logic        freq_reduction,
  input  wire logic        decel_ramp,
  input  wire logic        accel_ramp,
  input  wire logic        ramp_frozen,
  input  wire logic        setpoint_ok,
  input  wire logic        dc_link_reg,
  input  wire logic        cfg_50hz,
  input  wire logic        ride_through,
  input  wire logic        flying_start,
  input  wire logic        dc_braking,
  input  wire logic        pulses_on,
  // signed output frequency, same unit as the rated setting
  input  wire logic [15:0] out_freq,
  // rated frequency setting, for the rest of the drive
  output logic [15:0]      rated_motor_frequency
);
  import dswb_pkg::*;

  typedef struct packed {
    logic [31:0]    prdata;
    logic           pslverr;
    logic [15:0]    rated;
    logic [15:0]    speed;
    logic [15:0]    mag;
    logic [15:0]    den;
    logic           neg;
    dswb_sp_state_t st;
  } dswb_top_state_t;

  dswb_top_state_t s_reg;
  dswb_top_state_t s_next;

  dswb_word_if words ();
  dswb_div_if  div ();

  logic setup_rd;
  logic access_wr;
  logic [15:0] freq_mag;

  // saturating signed result from magnitude quotient and sign
  function automatic logic [15:0] sat_speed(input logic [28:0] q, input logic neg);
    logic [15:0] res;
    if (neg) begin
      if (q >= `DSWB_Q_MIN_MAG) begin
        res = `DSWB_SPEED_MIN;
      end else begin
        res = 16'(~q[15:0] + 16'h0001);
      end
    end else if (q > `DSWB_Q_MAX) begin
      res = `DSWB_SPEED_MAX;
    end else begin
      res = q[15:0];
    end
    return res;
  endfunction : sat_speed

  // magnitude of a two's-complement word; 8000h stays 8000h
  function automatic logic [15:0] abs16(input logic [15:0] v);
    return v[15] ? 16'(~v + 16'h0001) : v;
  endfunction : abs16

  assign words.flags = '{
    run_cmd:          run_cmd,
    fire_mode:        fire_mode,
    second_ramp:      second_ramp,
    config_state:     config_state,
    alarm:            alarm,
    running:          running,
    enabled:          enabled,
    forward:          forward,
    inching_function: inching_function,
    remote:           remote,
    undervoltage:     undervoltage,
    fault:            fault,
    dc_link_extended: dc_link_extended,
    energy_saving:    energy_saving,
    freq_reduction:   freq_reduction,
    decel_ramp:       decel_ramp,
    accel_ramp:       accel_ramp,
    ramp_frozen:      ramp_frozen,
    setpoint_ok:      setpoint_ok,
    dc_link_reg:      dc_link_reg,
    cfg_50hz:         cfg_50hz,
    ride_through:     ride_through,
    flying_start:     flying_start,
    dc_braking:       dc_braking,
    pulses_on:        pulses_on
  };

  dswb_word_pack u_pack (
    .pclk    (pclk),
    .presetn (presetn),
    .words   (words)
  );

  dswb_speed_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (div)
  );

  assign freq_mag     = abs16(out_freq);
  assign div.start    = (s_reg.st == DSWB_SP_IDLE);
  assign div.dividend = {freq_mag, `DSWB_SCALE_SHIFT};
  assign div.divisor  = s_reg.den;

  assign setup_rd  = psel & ~penable & ~pwrite;
  assign access_wr = psel & penable & pwrite;

  always_comb begin
    s_next = s_reg;
    // speed is refreshed continuously; a read sees the last finished division
    case (s_reg.st)
      DSWB_SP_IDLE: begin
        s_next.mag = freq_mag;
        s_next.neg = out_freq[15];
        // divisor frozen per pass so a rated write never mixes two divisors
        s_next.den = s_reg.rated;
        s_next.st  = DSWB_SP_WAIT;
      end
      DSWB_SP_WAIT: begin
        if (div.done) begin
          s_next.speed = sat_speed(div.quotient, s_reg.neg);
          s_next.st    = DSWB_SP_IDLE;
        end
      end
      default: begin
        s_next.st = DSWB_SP_IDLE;
      end
    endcase
    // read data captured in setup so the access phase answers at once
    if (setup_rd) begin
      s_next.pslverr = 1'b0;
      if (paddr == `DSWB_ADDR_STATUS) begin
        s_next.prdata = {`DSWB_WORD_ZERO, words.primary};
      end else if (paddr == `DSWB_ADDR_SPEED) begin
        s_next.prdata = {`DSWB_WORD_ZERO, s_reg.speed};
      end else if (paddr == `DSWB_ADDR_STATUS2) begin
        s_next.prdata = {`DSWB_WORD_ZERO, words.secondary};
      end else if (paddr == `DSWB_ADDR_RATED) begin
        s_next.prdata = {`DSWB_WORD_ZERO, s_reg.rated};
      end else begin
        s_next.prdata  = '0;
        s_next.pslverr = 1'b1;
      end
    end else if (psel & ~penable) begin
      s_next.prdata  = '0;
      s_next.pslverr = !((paddr == `DSWB_ADDR_STATUS) || (paddr == `DSWB_ADDR_SPEED)
                         || (paddr == `DSWB_ADDR_STATUS2) || (paddr == `DSWB_ADDR_RATED));
    end
    // status words have no storage to write, so writes just complete
    if (access_wr && (paddr == `DSWB_ADDR_RATED)) begin
      s_next.rated = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg       <= '0;
      s_reg.rated <= `DSWB_RATED_RESET;
      s_reg.st    <= DSWB_SP_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pready                = 1'b1;
  assign prdata                = s_reg.prdata;
  assign pslverr               = s_reg.pslverr;
  assign rated_motor_frequency = s_reg.rated;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rd_status;
    setup_rd && (paddr == `DSWB_ADDR_STATUS);
  endsequence

  sequence s_rd_status2;
    setup_rd && (paddr == `DSWB_ADDR_STATUS2);
  endsequence

  sequence s_rd_speed;
    setup_rd && (paddr == `DSWB_ADDR_SPEED);
  endsequence

  sequence s_div_end;
    (s_reg.st == DSWB_SP_WAIT) && div.done;
  endsequence

  a_write_ignored : assert property (
    access_wr && ((paddr == `DSWB_ADDR_STATUS) || (paddr == `DSWB_ADDR_SPEED)
                  || (paddr == `DSWB_ADDR_STATUS2)) |=> $stable(s_reg.rated))
    else $error("read-only write changed state");

  a_mapped_no_error : assert property (
    psel && !penable && ((paddr == `DSWB_ADDR_STATUS) || (paddr == `DSWB_ADDR_SPEED)
                         || (paddr == `DSWB_ADDR_STATUS2)) |=> !pslverr)
    else $error("status access flagged an error");

  a_run_bit : assert property (
    s_rd_status |=> prdata[`DSWB_P_RUN_CMD] == $past(run_cmd, 2))
    else $error("run bit wrong");

  a_fire_bit : assert property (
    s_rd_status |=> prdata[`DSWB_P_FIRE] == $past(fire_mode, 2))
    else $error("override bit wrong");

  a_ramp_pair : assert property (
    s_rd_status |=> prdata[`DSWB_P_RAMP2] == $past(second_ramp, 2))
    else $error("ramp pair bit wrong");

  a_config_bit : assert property (
    s_rd_status |=> prdata[`DSWB_P_CONFIG] == $past(config_state, 2))
    else $error("config bit wrong");

  a_alarm_bit : assert property (
    s_rd_status |=> prdata[`DSWB_P_ALARM] == $past(alarm, 2))
    else $error("alarm bit wrong");

  a_run_enable : assert property (
    s_rd_status |=> prdata[`DSWB_P_ENABLED:`DSWB_P_RUNNING]
                    == {$past(enabled, 2), $past(running, 2)})
    else $error("running or enabled bit wrong");

  a_dir_remote : assert property (
    s_rd_status |=> (prdata[`DSWB_P_FORWARD] == $past(forward, 2))
                    && (prdata[`DSWB_P_REMOTE] == $past(remote, 2)))
    else $error("direction or remote bit wrong");

  a_uv_fault : assert property (
    s_rd_status |=> (prdata[`DSWB_P_UNDERVOLT] == $past(undervoltage, 2))
                    && (prdata[`DSWB_P_FAULT] == $past(fault, 2)))
    else $error("undervoltage or fault bit wrong");

  a_reserved_zero : assert property (
    s_rd_status |=> (prdata[31:16] == 16'h0000) && !prdata[0] && !prdata[3]
                    && !prdata[4] && !prdata[14])
    else $error("reserved primary bit set");

  a_second_low : assert property (
    s_rd_status2 |=> prdata[8:2] == {$past(ramp_frozen, 2), $past(accel_ramp, 2),
                                     $past(decel_ramp, 2), 1'b0,
                                     $past(freq_reduction, 2), $past(energy_saving, 2),
                                     $past(dc_link_extended, 2)})
    else $error("secondary low flags wrong");

  a_second_high : assert property (
    s_rd_status2 |=> prdata[15:9] == {$past(pulses_on, 2), $past(dc_braking, 2),
                                      $past(flying_start, 2), $past(ride_through, 2),
                                      $past(cfg_50hz, 2), $past(dc_link_reg, 2),
                                      $past(setpoint_ok, 2)})
    else $error("secondary high flags wrong");

  a_second_reserved : assert property (
    s_rd_status2 |=> (prdata[31:16] == 16'h0000) && (prdata[1:0] == 2'b00))
    else $error("reserved secondary bit set");

  a_speed_read : assert property (
    s_rd_speed |=> (prdata[31:16] == 16'h0000) && (prdata[15:0] == $past(s_reg.speed)))
    else $error("speed read wrong");

  a_speed_rated : assert property (
    s_div_end and ((s_reg.mag == s_reg.den) && !s_reg.neg && (s_reg.den != 16'h0000))
    |=> s_reg.speed == `DSWB_SPEED_RATED)
    else $error("rated frequency not 2000h");

  a_speed_zero : assert property (
    s_div_end and (s_reg.mag == 16'h0000) && (s_reg.den != 16'h0000)
    |=> s_reg.speed == `DSWB_SPEED_ZERO)
    else $error("zero frequency not zero");

  a_speed_clamp : assert property (
    s_div_end and (div.quotient > `DSWB_Q_MAX) && !s_reg.neg
    |=> s_reg.speed == `DSWB_SPEED_MAX)
    else $error("positive speed not clamped");

  a_speed_floor : assert property (
    s_div_end and s_reg.neg && (div.quotient >= `DSWB_Q_MIN_MAG)
    |=> s_reg.speed == `DSWB_SPEED_MIN)
    else $error("negative speed not clamped");

  a_speed_sign : assert property (
    s_div_end and s_reg.neg && (div.quotient != 29'h00000000)
    |=> s_reg.speed[15])
    else $error("negative speed lost its sign");

  a_div_ready : assert property (
    (s_reg.st == DSWB_SP_IDLE) |-> !div.busy)
    else $error("divider busy at pass start");

  a_speed_fresh : assert property (
    (s_reg.st == DSWB_SP_IDLE) |=> (s_reg.st == DSWB_SP_WAIT) ##[29:31] div.done)
    else $error("speed refresh overdue");
endmodule : dswb_top

// >>> sim/drive_status_word_bank_tb.sv
// self-checking bench of the drive status word bank
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module drive_status_word_bank_tb;
  import dswb_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [24:0] fl;
  logic [15:0] out_freq;
  logic [15:0] rated;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          samples_checked;
  int          rt;
  dswb_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .run_cmd(fl[0]), .fire_mode(fl[1]), .second_ramp(fl[2]), .config_state(fl[3]),
    .alarm(fl[4]), .running(fl[5]), .enabled(fl[6]), .forward(fl[7]),
    .inching_function(fl[8]), .remote(fl[9]), .undervoltage(fl[10]), .fault(fl[11]),
    .dc_link_extended(fl[12]), .energy_saving(fl[13]), .freq_reduction(fl[14]),
    .decel_ramp(fl[15]), .accel_ramp(fl[16]), .ramp_frozen(fl[17]), .setpoint_ok(fl[18]),
    .dc_link_reg(fl[19]), .cfg_50hz(fl[20]), .ride_through(fl[21]), .flying_start(fl[22]),
    .dc_braking(fl[23]), .pulses_on(fl[24]), .out_freq(out_freq),
    .rated_motor_frequency(rated)
  );
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // expected words, reserved bits forced low
  function automatic logic [31:0] prim(logic [24:0] f);
    return {16'h0000, f[11], 1'b0, f[10:2], 2'b00, f[1:0], 1'b0};
  endfunction : prim
  function automatic logic [31:0] sec(logic [24:0] f);
    return {16'h0000, f[24:15], 1'b0, f[14:12], 2'b00};
  endfunction : sec
  // truncation toward zero, then clamp to the signed range
  function automatic logic [31:0] spd(logic [15:0] f, logic [15:0] r);
    int m;
    int q;
    m = f[15] ? 65536 - int'(f) : int'(f);
    q = (m * 8192) / int'(r);
    if (!f[15]) return (q > 32767) ? 32'h00007fff : 32'(q);
    return (q > 32768) ? 32'h00008000 : {16'h0000, 16'(-q)};
  endfunction : spd
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic close_out;
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    #100us;
    errors++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    fl = '0;
    out_freq = 16'h0000;
    presetn = 1'b0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(32'h93b98170));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(rated, 16'h0258)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(rd, 32'h00000258)
    // flag words, all-low and all-high corners first
    for (int i = 0; i < 22; i++) begin
      @(posedge pclk);
      fl <= (i == 0) ? 25'h0 : (i == 1) ? 25'h1ffffff : 25'($urandom);
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      `CHK(rd, prim(fl))
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd, sec(fl))
      apb(1'b1, 12'h000, $urandom);
      `CHK(er, 1'b0)
      apb(1'b1, 12'h008, $urandom);
      `CHK(er, 1'b0)
      apb(1'b0, 12'h000, 32'h0);
      `CHK(rd, prim(fl))
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd, sec(fl))
    end
    // unmapped places answer with an error and zero data
    apb(1'b0, 12'h010, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    apb(1'b1, 12'hffc, 32'h0);
    `CHK(er, 1'b1)
    // speed scaling: fixed corners, then random rated and frequency
    for (int i = 0; i < 18; i++) begin
      rt = (i < 7) ? 600 : $urandom_range(65535, 1);
      @(posedge pclk);
      case (i)
        0: out_freq <= 16'd0;
        1: out_freq <= 16'd600;
        2: out_freq <= -16'sd600;
        3: out_freq <= 16'd2400;
        4: out_freq <= -16'sd2400;
        5: out_freq <= 16'd2399;
        6: out_freq <= 16'h8000;
        default: out_freq <= 16'($urandom);
      endcase
      apb(1'b1, 12'h00c, {16'($urandom), 16'(rt)});
      apb(1'b0, 12'h00c, 32'h0);
      `CHK(rd, 32'(rt))
      `CHK(rated, 16'(rt))
      repeat (80) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd, spd(out_freq, 16'(rt)))
      apb(1'b1, 12'h004, 32'h00001234);
      `CHK(er, 1'b0)
    end
    close_out();
  end
endmodule : drive_status_word_bank_tb
